// *** core/api_tx_frame_and_timeout.sv ***
// API frame receiver/checker with transmit-attempt timeout engine.
// Assumes host bytes arrive as a valid/ready stream synchronous to clk.
//
// Function
// - Remote end device attempt waits 50 ms times hop factor plus sleep period.
// - One attempt plus two retries toward a remote end device.
// - Sleep setting counts in 10 ms units.
// - Checksum is 0xFF minus low byte of sum after length; verified.
// - Transmit status returned only for nonzero frame identifier.
// - All-zero 64-bit destination means coordinator, with 0xFFFE short address.
// - Destination 0000FFFF with 0xFFFE is a broadcast to every node.
// - Broadcast radius zero means maximum hop count.
// - Addressing option on: data delivered as explicit frame 0x91.
// - Device-profile messages go to host only while addressing option is one.
// - Router attempt timeout is 50 ms times hop factor plus 100 ms.
// - Hop factor resets to thirty.
`timescale 1ns/1ns
`default_nettype none
`include "api_frame_map.svh"
module api_tx_frame_and_timeout
    import api_frame_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int MS_CYCLES  = `CYC_PER_MS
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    nrst,
    // Host byte stream
    input  wire logic [7:0]              host_data,
    input  wire logic                    host_valid,
    output logic                         host_ready,
    // Register port
    input  wire logic [3:0]              reg_addr,
    input  wire logic [15:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [15:0]                  reg_rdata,
    // Accepted request toward the radio
    output logic                         req_valid,
    output logic [63:0]                  req_dest64,
    output logic [15:0]                  req_dest16,
    output logic [7:0]                   req_radius,
    output logic [7:0]                   req_frame_id,
    output api_frame_pkg::dest_kind_e    req_kind,
    output logic                         req_to_end_device,
    output logic                         req_status_wanted,
    // Radio results
    input  wire logic                    radio_ack,
    input  wire logic                    rx_is_zdo,
    // Outcomes
    output logic                         tx_status_pulse,
    output logic                         tx_failed,
    output logic                         tx_busy,
    output logic [7:0]                   rx_frame_type,
    output logic                         zdo_pass,
    // Payload out
    output logic [7:0]                   pay_data,
    output logic                         pay_valid,
    input  wire logic                    pay_ready
);
    if (FIFO_DEPTH < 2 || MS_CYCLES < 1) begin : bad_params
        $error("api_tx_frame_and_timeout: bad parameter");
    end

    byte_stream_if #(.WIDTH(8)) fin ();
    byte_stream_if #(.WIDTH(8)) fout ();

    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk  (clk),
        .nrst (nrst),
        .wr   (fin.sink),
        .rd   (fout.source)
    );

    // Settings
    logic [7:0]  hop_timeout_factor_reg;
    logic [15:0] sleep_period_setting_reg;
    logic [7:0]  rx_addressing_option_reg;
    logic [15:0] frame_count_reg;
    logic [15:0] error_count_reg;

    // Parser
    parse_state_e state_reg;
    logic [15:0]  len_reg;
    logic [15:0]  idx_reg;
    logic [7:0]   sum_reg;
    logic [7:0]   api_id_reg;
    logic [7:0]   fid_reg;
    logic [63:0]  d64_reg;
    logic [15:0]  d16_reg;
    logic [7:0]   rad_reg;
    logic [7:0]   opt_reg;
    logic [15:0]  cmd_reg;
    logic [7:0]   cmd_val_reg;
    logic         take;
    logic         in_payload;
    logic         frame_ok;
    logic         frame_bad;

    assign take       = host_valid && host_ready;
    // Payload bytes hold the parser when the FIFO is full
    assign in_payload = (state_reg == ST_BODY) && (api_id_reg == `ID_TX_REQUEST)
                        && (idx_reg >= 16'd14);
    assign host_ready = !in_payload || fin.ready;
    assign fin.data   = host_data;
    assign fin.valid  = take && in_payload;
    assign fout.ready = pay_ready;
    assign pay_data   = fout.data;
    assign pay_valid  = fout.valid;

    assign frame_ok  = take && (state_reg == ST_CSUM)
                       && (host_data == 8'(`CHECKSUM_BASE - sum_reg));
    assign frame_bad = take && (state_reg == ST_CSUM) && !frame_ok;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            len_reg   <= '0;
            idx_reg   <= '0;
            sum_reg   <= '0;
        end else if (take) begin
            case (state_reg)
                ST_IDLE: begin
                    if (host_data == `START_BYTE)
                        state_reg <= ST_LEN_HI;
                end
                ST_LEN_HI: begin
                    len_reg[15:8] <= host_data;
                    state_reg     <= ST_LEN_LO;
                end
                ST_LEN_LO: begin
                    len_reg[7:0] <= host_data;
                    idx_reg      <= '0;
                    sum_reg      <= '0;
                    // Empty frame cannot be checked; resync
                    state_reg    <= ({len_reg[15:8], host_data} == 16'h0000) ? ST_IDLE : ST_BODY;
                end
                ST_BODY: begin
                    sum_reg <= sum_reg + host_data;
                    idx_reg <= idx_reg + 16'd1;
                    if (idx_reg + 16'd1 == len_reg)
                        state_reg <= ST_CSUM;
                end
                ST_CSUM: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Header field capture, big-endian
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            api_id_reg  <= '0;
            fid_reg     <= '0;
            d64_reg     <= '0;
            d16_reg     <= '0;
            rad_reg     <= '0;
            opt_reg     <= '0;
            cmd_reg     <= '0;
            cmd_val_reg <= '0;
        end else if (take && state_reg == ST_BODY) begin
            if (idx_reg == 16'd0)
                api_id_reg <= host_data;
            else if (idx_reg == 16'd1)
                fid_reg <= host_data;
            else if (api_id_reg == `ID_TX_REQUEST) begin
                if (idx_reg <= 16'd9)
                    d64_reg <= {d64_reg[55:0], host_data};
                else if (idx_reg <= 16'd11)
                    d16_reg <= {d16_reg[7:0], host_data};
                else if (idx_reg == 16'd12)
                    rad_reg <= host_data;
                else if (idx_reg == 16'd13)
                    opt_reg <= host_data;
            end else if (api_id_reg == `ID_AT_COMMAND) begin
                if (idx_reg <= 16'd3)
                    cmd_reg <= {cmd_reg[7:0], host_data};
                else if (idx_reg == 16'd4)
                    cmd_val_reg <= host_data;
            end
        end
    end

    // Settings and register writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hop_timeout_factor_reg   <= `HOP_FACTOR_RESET;
            sleep_period_setting_reg <= `SLEEP_PERIOD_RESET;
            rx_addressing_option_reg <= `ADDR_OPT_RESET;
        end else if (frame_ok && api_id_reg == `ID_AT_COMMAND
                     && cmd_reg == `CMD_RX_ADDRESSING && len_reg == 16'd5) begin
            rx_addressing_option_reg <= cmd_val_reg;
        end else if (reg_wr) begin
            case (reg_addr)
                `REG_HOP_FACTOR:   hop_timeout_factor_reg   <= reg_wdata[7:0];
                `REG_SLEEP_PERIOD: sleep_period_setting_reg <= reg_wdata;
                `REG_ADDR_OPTION:  rx_addressing_option_reg <= reg_wdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_count_reg <= '0;
            error_count_reg <= '0;
        end else begin
            if (frame_ok)
                frame_count_reg <= frame_count_reg + 16'd1;
            if (frame_bad)
                error_count_reg <= error_count_reg + 16'd1;
        end
    end

    // Request decode
    dest_kind_e kind_now;
    always_comb begin
        if (d64_reg == `DEST64_BROADCAST && d16_reg == `DEST16_UNKNOWN)
            kind_now = DEST_BROADCAST;
        else if (d64_reg == `DEST64_COORD)
            kind_now = DEST_COORD;
        else
            kind_now = DEST_UNICAST;
    end

    logic start_tx;
    assign start_tx = frame_ok && api_id_reg == `ID_TX_REQUEST && len_reg >= 16'd14
                      && !(d64_reg == `DEST64_COORD && d16_reg != `DEST16_UNKNOWN);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_valid         <= 1'b0;
            req_dest64        <= '0;
            req_dest16        <= '0;
            req_radius        <= '0;
            req_frame_id      <= '0;
            req_kind          <= DEST_UNICAST;
            req_to_end_device <= 1'b0;
            req_status_wanted <= 1'b0;
        end else begin
            req_valid <= start_tx;
            if (start_tx) begin
                req_dest64        <= d64_reg;
                req_dest16        <= d16_reg;
                req_radius        <= (rad_reg == 8'h00) ? `RADIUS_MAX_HOPS : rad_reg;
                req_frame_id      <= fid_reg;
                req_kind          <= kind_now;
                req_to_end_device <= opt_reg[0];
                req_status_wanted <= (fid_reg != 8'h00);
            end
        end
    end

    // Attempt timer, counted in cycles then ms
    tmo_state_e tstate_reg;
    logic [31:0] ms_limit;
    logic [31:0] ms_reg;
    logic [31:0] cyc_reg;
    logic [1:0]  attempt_reg;
    logic        ed_reg;
    logic        want_status_reg;
    logic        attempt_end;

    always_comb begin
        if (ed_reg)
            ms_limit = `HOP_MS * 32'(hop_timeout_factor_reg)
                       + `SLEEP_UNIT_MS * 32'(sleep_period_setting_reg);
        else
            ms_limit = `HOP_MS * 32'(hop_timeout_factor_reg) + `ROUTER_EXTRA_MS;
    end

    assign attempt_end = (tstate_reg == TMO_RUN) && (cyc_reg == 32'(MS_CYCLES - 1))
                         && (ms_reg + 32'd1 >= ms_limit);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tstate_reg      <= TMO_IDLE;
            ms_reg          <= '0;
            cyc_reg         <= '0;
            attempt_reg     <= '0;
            ed_reg          <= 1'b0;
            want_status_reg <= 1'b0;
        end else begin
            case (tstate_reg)
                TMO_IDLE: begin
                    if (req_valid && req_kind == DEST_UNICAST) begin
                        tstate_reg      <= TMO_RUN;
                        ms_reg          <= '0;
                        cyc_reg         <= '0;
                        attempt_reg     <= 2'd1;
                        ed_reg          <= req_to_end_device;
                        want_status_reg <= req_status_wanted;
                    end
                end
                TMO_RUN: begin
                    if (radio_ack)
                        tstate_reg <= TMO_IDLE;
                    else if (attempt_end) begin
                        ms_reg  <= '0;
                        cyc_reg <= '0;
                        if (attempt_reg == `TX_ATTEMPTS)
                            tstate_reg <= TMO_FAILED;
                        else
                            attempt_reg <= attempt_reg + 2'd1;
                    end else if (cyc_reg == 32'(MS_CYCLES - 1)) begin
                        cyc_reg <= '0;
                        ms_reg  <= ms_reg + 32'd1;
                    end else
                        cyc_reg <= cyc_reg + 32'd1;
                end
                TMO_FAILED: tstate_reg <= TMO_IDLE;
                default:    tstate_reg <= TMO_IDLE;
            endcase
        end
    end

    logic done_now;
    assign done_now = (tstate_reg == TMO_FAILED)
                      || (tstate_reg == TMO_RUN && radio_ack);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_status_pulse <= 1'b0;
            tx_failed       <= 1'b0;
        end else begin
            tx_status_pulse <= done_now && want_status_reg;
            if (done_now)
                tx_failed <= (tstate_reg == TMO_FAILED);
        end
    end

    assign tx_busy = (tstate_reg != TMO_IDLE);

    // Receive delivery format
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_frame_type <= `ID_RX_PLAIN;
            zdo_pass      <= 1'b0;
        end else begin
            rx_frame_type <= (rx_addressing_option_reg == 8'h01) ? `ID_RX_EXPLICIT : `ID_RX_PLAIN;
            zdo_pass      <= rx_is_zdo && (rx_addressing_option_reg == 8'h01);
        end
    end

    // Register read, data one cycle after strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            reg_rdata <= '0;
        else if (reg_rd) begin
            case (reg_addr)
                `REG_HOP_FACTOR:   reg_rdata <= {8'h00, hop_timeout_factor_reg};
                `REG_SLEEP_PERIOD: reg_rdata <= sleep_period_setting_reg;
                `REG_ADDR_OPTION:  reg_rdata <= {8'h00, rx_addressing_option_reg};
                `REG_STATUS:       reg_rdata <= {12'h000, tx_failed, tx_busy, 2'(tstate_reg)};
                `REG_FRAME_COUNT:  reg_rdata <= frame_count_reg;
                `REG_ERROR_COUNT:  reg_rdata <= error_count_reg;
                `REG_LAST_DEST16:  reg_rdata <= req_dest16;
                default:           reg_rdata <= 16'h0000;
            endcase
        end else
            reg_rdata <= 16'h0000;
    end

    chk_status_gate: assert property (@(posedge clk) disable iff (!nrst)
        tx_status_pulse |-> $past(want_status_reg))
        else $error("status sent for zero frame id");
    chk_radius_max: assert property (@(posedge clk) disable iff (!nrst)
        start_tx && rad_reg == 8'h00 |=> req_radius == `RADIUS_MAX_HOPS)
        else $error("zero radius not mapped to max hops");
    chk_bad_resync: assert property (@(posedge clk) disable iff (!nrst)
        frame_bad |=> state_reg == ST_IDLE && !req_valid)
        else $error("bad frame accepted");
    chk_hop_reset: assert property (@(posedge clk)
        $rose(nrst) |-> hop_timeout_factor_reg == `HOP_FACTOR_RESET)
        else $error("hop factor reset wrong");
    chk_explicit_fmt: assert property (@(posedge clk) disable iff (!nrst)
        rx_addressing_option_reg == 8'h01 && $stable(rx_addressing_option_reg) |=> rx_frame_type == `ID_RX_EXPLICIT)
        else $error("explicit format not used");
    chk_zdo_gate: assert property (@(posedge clk) disable iff (!nrst)
        zdo_pass |-> $past(rx_addressing_option_reg) == 8'h01)
        else $error("zdo passed with option off");
    chk_three_tries: assert property (@(posedge clk) disable iff (!nrst)
        tstate_reg == TMO_FAILED |-> attempt_reg == `TX_ATTEMPTS)
        else $error("failed before three attempts");
    chk_broadcast_kind: assert property (@(posedge clk) disable iff (!nrst)
        start_tx && d64_reg == `DEST64_BROADCAST && d16_reg == `DEST16_UNKNOWN |=> req_kind == DEST_BROADCAST)
        else $error("broadcast not recognised");
    chk_ed_limit: assert property (@(posedge clk) disable iff (!nrst)
        tstate_reg == TMO_RUN && ed_reg |-> ms_reg <= `HOP_MS * 32'(hop_timeout_factor_reg)
            + `SLEEP_UNIT_MS * 32'(sleep_period_setting_reg))
        else $error("end device limit wrong");
endmodule
`default_nettype wire

// *** core/api_frame_map.svh ***
// Offsets, field codes, reset values and timing counts for the API frame block.
// Included by package-aware design files; holds definitions only.
`ifndef API_FRAME_MAP_SVH
`define API_FRAME_MAP_SVH

`define START_BYTE          8'h7e
`define ID_TX_REQUEST       8'h10
`define ID_AT_COMMAND       8'h08
`define ID_RX_EXPLICIT      8'h91
`define ID_RX_PLAIN         8'h90
`define CHECKSUM_BASE       8'hff
`define CMD_RX_ADDRESSING   16'h414f
`define DEST16_UNKNOWN      16'hfffe
`define DEST16_COORD_KNOWN  16'h0000
`define DEST64_COORD        64'h0000_0000_0000_0000
`define DEST64_BROADCAST    64'h0000_0000_0000_ffff
`define RADIUS_MAX_HOPS     8'h1e
`define HOP_FACTOR_RESET    8'h1e
`define SLEEP_PERIOD_RESET  16'h0020
`define ADDR_OPT_RESET      8'h00
`define TX_ATTEMPTS         2'd3
// Timing: figures in ms, per-ms cycle count derived from 100 MHz
`define CLK_MHZ             100
`define HOP_MS              50
`define ROUTER_EXTRA_MS     100
`define SLEEP_UNIT_MS       10
`define CYC_PER_MS          (`CLK_MHZ * 1000)
// Register indices for the plain register port
`define REG_HOP_FACTOR      4'h0
`define REG_SLEEP_PERIOD    4'h1
`define REG_ADDR_OPTION     4'h2
`define REG_STATUS          4'h3
`define REG_FRAME_COUNT     4'h4
`define REG_ERROR_COUNT     4'h5
`define REG_LAST_DEST16     4'h6

`endif

// *** core/api_frame_pkg.sv ***
// Types shared by the API frame block.
// Assumes the map header for numeric constants.
package api_frame_pkg;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0000,
        ST_LEN_HI = 4'b0001,
        ST_LEN_LO = 4'b0010,
        ST_BODY   = 4'b0011,
        ST_CSUM   = 4'b0100
    } parse_state_e;

    typedef enum logic [1:0] {
        DEST_UNICAST   = 2'b00,
        DEST_COORD     = 2'b01,
        DEST_BROADCAST = 2'b10
    } dest_kind_e;

    typedef enum logic [1:0] {
        TMO_IDLE    = 2'b00,
        TMO_RUN     = 2'b01,
        TMO_FAILED  = 2'b10
    } tmo_state_e;
endpackage

// *** core/byte_stream_if.sv ***
// Valid/ready byte stream between the framer and its FIFO.
// Assumes both ends share clk.
`timescale 1ns/1ns
`default_nettype none
interface byte_stream_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] data;
    logic             valid;
    logic             ready;
    modport source (output data, output valid, input ready);
    modport sink   (input data, input valid, output ready);
endinterface
`default_nettype wire

// *** core/byte_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty derived from a count.
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  nrst,
    // Streams
    byte_stream_if.sink   wr,
    byte_stream_if.source rd
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : bad_depth
        $error("byte_fifo: depth must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_reg;
    logic [AW-1:0]    rp_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    assign wr.ready = (cnt_reg != (AW+1)'(DEPTH));
    assign rd.valid = (cnt_reg != '0);
    assign rd.data  = mem[rp_reg];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_reg] <= wr.data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push)
                wp_reg <= wp_reg + 1'b1;
            if (pop)
                rp_reg <= rp_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    chk_no_overflow: assert property (@(posedge clk) disable iff (!nrst)
        cnt_reg == (AW+1)'(DEPTH) |-> !push)
        else $error("fifo written while full");
endmodule
`default_nettype wire

// *** sim/host_model.sv ***
// Host controller model: frames API bytes onto the valid/ready byte stream.
// Assumes host_ready is sampled at the rising edge of clk.
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Byte stream
    output logic [7:0]      host_data,
    output logic            host_valid,
    input  wire logic       host_ready
);
    logic [7:0] q[$];
    function automatic void send(input logic [7:0] body[$], input bit bad);
        logic [7:0] sum;
        sum = 8'h00;
        foreach (body[i]) sum += body[i];
        q.push_back(8'h7e);
        q.push_back(8'(body.size() >> 8));
        q.push_back(8'(body.size()));
        foreach (body[i]) q.push_back(body[i]);
        q.push_back((8'hff - sum) ^ {7'h00, bad});
    endfunction
    // Idle data toggles so a stale byte never passes for a fresh one
    // Plain always: the queue is also filled by send() from the bench
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            host_valid <= 1'b0;
            host_data  <= 8'h00;
        end else if (!host_valid || host_ready) begin
            if (q.size() > 0) begin
                host_data  <= q.pop_front();
                host_valid <= 1'b1;
            end else begin
                host_valid <= 1'b0;
                host_data  <= ~host_data;
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/api_tx_frame_and_timeout_test.sv ***
// Self-checking bench: frames, registers, payload FIFO and attempt timer.
// Assumes MS_CYCLES shrunk to 10 cycles so timeouts stay short.
`timescale 1ns/1ns
`default_nettype none
module api_tx_frame_and_timeout_test;
    import api_frame_pkg::*;
    localparam int MS = 10;
    logic        clk, nrst, host_valid, host_ready, reg_wr, reg_rd, req_valid, req_to_end_device;
    logic        req_status_wanted, radio_ack, rx_is_zdo, tx_status_pulse, tx_failed, tx_busy;
    logic        zdo_pass, pay_valid, pay_ready, hold, saw_full = 1'b0;
    logic [7:0]  host_data, req_radius, req_frame_id, rx_frame_type, pay_data;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, req_dest16;
    logic [63:0] req_dest64, last64;
    dest_kind_e  req_kind;
    logic [7:0]  exp_pay[$];
    logic [31:0] seed = 32'd71;
    int          error_cnt = 0;
    int          checked = 0;

    api_tx_frame_and_timeout #(.FIFO_DEPTH(16), .MS_CYCLES(MS)) api_tx_frame_and_timeout_inst (
        .clk(clk), .nrst(nrst), .host_data(host_data), .host_valid(host_valid), .host_ready(host_ready),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .req_valid(req_valid), .req_dest64(req_dest64), .req_dest16(req_dest16), .req_radius(req_radius),
        .req_frame_id(req_frame_id), .req_kind(req_kind), .req_to_end_device(req_to_end_device),
        .req_status_wanted(req_status_wanted), .radio_ack(radio_ack), .rx_is_zdo(rx_is_zdo),
        .tx_status_pulse(tx_status_pulse), .tx_failed(tx_failed), .tx_busy(tx_busy),
        .rx_frame_type(rx_frame_type), .zdo_pass(zdo_pass), .pay_data(pay_data), .pay_valid(pay_valid),
        .pay_ready(pay_ready));
    host_model host_model_inst (.clk(clk), .nrst(nrst), .host_data(host_data), .host_valid(host_valid),
        .host_ready(host_ready));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic int span(input int hop, input int slp, input bit ed);
        return 3 * (50 * hop + (ed ? 10 * slp : 100)) * MS;
    endfunction
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rdata", reg_rdata, e);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic tx(input logic [63:0] d64, input logic [15:0] d16, input logic [7:0] fid, opts, rad,
                      input int np, input bit bad);
        logic [7:0] b[$];
        logic [7:0] r;
        b = {8'h10, fid};
        for (int i = 7; i >= 0; i--) b.push_back(d64[i*8+:8]);
        b.push_back(d16[15:8]);
        b.push_back(d16[7:0]);
        b.push_back(rad);
        b.push_back(opts);
        for (int i = 0; i < np; i++) begin
            r = rnd();
            b.push_back(r);
            exp_pay.push_back(r);
        end
        last64 = d64;
        host_model_inst.send(b, bad);
    endtask
    task automatic wait_req(input bit want);
        bit got;
        got = 1'b0;
        for (int i = 0; i < 300 && !got; i++) begin
            @(posedge clk);
            #1;
            got = (req_valid === 1'b1);
        end
        check("req_valid", got, want);
    endtask
    task automatic measure(input int exp);
        int n;
        for (n = 0; n < 6000; n++) begin
            #1;
            if (tx_status_pulse === 1'b1) break;
            @(posedge clk);
        end
        check("attempt_span", n >= exp - 4 && n <= exp + 4, 1);
    endtask
    // Far side stalls every other cycle once released
    always @(posedge clk) pay_ready <= hold ? 1'b0 : ~pay_ready;
    always @(posedge clk) if (host_valid && !host_ready) saw_full <= 1'b1;
    always @(posedge clk) if (nrst && pay_valid && pay_ready) check("pay_data", pay_data, exp_pay.pop_front());

    initial begin
        {nrst, reg_addr, reg_wdata, reg_wr, reg_rd, radio_ack} = '0;
        rx_is_zdo = 1'b1;
        hold = 1'b1;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd(4'h0, 16'h001e);
        rd(4'h2, 16'h0000);
        rd(4'h7, 16'h0000);
        check("frame_type", rx_frame_type, 8'h90);
        check("zdo_pass", zdo_pass, 0);
        tx(64'h0, 16'hfffe, 8'h01, 8'h00, 8'h00, 20, 0);
        repeat (60) @(posedge clk);
        check("fifo_full", saw_full, 1);
        hold <= 1'b0;
        wait_req(1);
        check("kind", req_kind, DEST_COORD);
        check("radius", req_radius, 8'h1e);
        check("status", req_status_wanted, 1);
        repeat (40) @(posedge clk);
        check("drained", exp_pay.size() == 0 && pay_valid === 1'b0, 1);
        tx(64'h0000_ffff, 16'hfffe, 8'h00, 8'h00, 8'h07, 3, 0);
        wait_req(1);
        check("kind", req_kind, DEST_BROADCAST);
        check("status", req_status_wanted, 0);
        check("radius", req_radius, 8'h07);
        repeat (20) @(posedge clk);
        tx({rnd(), rnd(), 48'h0}, 16'h1234, 8'h01, 8'h00, 8'h00, 0, 1);
        wait_req(0);
        rd(4'h5, 16'h0001);
        host_model_inst.send({8'h08, 8'h01, 8'h41, 8'h4f, 8'h01}, 0);
        repeat (30) @(posedge clk);
        rd(4'h2, 16'h0001);
        check("frame_type", rx_frame_type, 8'h91);
        check("zdo_pass", zdo_pass, 1);
        @(posedge clk);
        rx_is_zdo <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check("zdo_pass", zdo_pass, 0);
        wr(4'h0, 16'h0001);
        wr(4'h1, 16'h0002);
        tx({rnd(), rnd(), 48'h1}, 16'h5555, 8'h05, 8'h00, 8'h00, 0, 0);
        wait_req(1);
        check("dest64", req_dest64, last64);
        check("dest16", req_dest16, 16'h5555);
        check("fid", req_frame_id, 8'h05);
        measure(span(1, 2, 0));
        check("failed", tx_failed, 1);
        tx({rnd(), rnd(), 48'h2}, 16'h5555, 8'h06, 8'h01, 8'h00, 0, 0);
        wait_req(1);
        check("end_dev", req_to_end_device, 1);
        measure(span(1, 2, 1));
        tx({rnd(), rnd(), 48'h3}, 16'h5555, 8'h09, 8'h00, 8'h00, 0, 0);
        wait_req(1);
        repeat (30) @(posedge clk);
        check("busy", tx_busy, 1);
        radio_ack <= 1'b1;
        @(posedge clk);
        radio_ack <= 1'b0;
        measure(1);
        check("failed", tx_failed, 0);
        report_and_stop();
    end
endmodule
`default_nettype wire
